// ### sep_pkg.sv
`default_nettype none
package sep_pkg;
  // clock and timing
  localparam int SEP_CLK_HZ = 10_000_000;
  localparam int SEP_CLK_NS = 1_000_000_000 / SEP_CLK_HZ;
  // watchdog trip time, rounded down to whole cycles
  localparam int SEP_WD_NS  = 6_500_000;
  localparam int SEP_WD_CYC = SEP_WD_NS / SEP_CLK_NS;
  localparam int SEP_WD_W   = 17;
  // index glitch filter, least pulse accepted, rounded up
  localparam int SEP_ZF_NS  = 175;
  localparam int SEP_ZF_CYC = (SEP_ZF_NS + SEP_CLK_NS - 1) / SEP_CLK_NS;
  localparam int SEP_ZF_W   = 3;
  // pwm carrier and quadrature widths
  localparam logic [10:0] SEP_PWM_PER = 11'h7FF;
  localparam int          SEP_QW      = 14;
  // register byte addresses
  localparam logic [7:0] SEP_OFS_CTRL = 8'h00;
  localparam logic [7:0] SEP_OFS_DOUT = 8'h04;
  localparam logic [7:0] SEP_OFS_INV  = 8'h08;
  localparam logic [7:0] SEP_OFS_DIN  = 8'h0C;
  localparam logic [7:0] SEP_OFS_STAT = 8'h10;
  localparam logic [3:0] SEP_PAGE_PWM = 4'h2;
  localparam logic [3:0] SEP_PAGE_Q   = 4'h3;
  // field positions
  localparam int SEP_CTRL_WDEN = 0;
  localparam int SEP_CTRL_SHUT = 1;
  localparam int SEP_CTRL_PDIR = 8;
  localparam int SEP_CTRL_PDM  = 12;
  localparam int SEP_PWM_SH    = 12;
  localparam int SEP_Q_IDX     = 14;
  localparam int SEP_ST_OE     = 0;
  localparam int SEP_ST_TRIP   = 1;
  localparam int SEP_INV_SH    = 10;
  // reset values
  localparam logic SEP_RST_WDEN = 1'b1;
  localparam logic SEP_RST_TRIP = 1'b1;

  // field-side input pins
  typedef struct packed {
    logic [3:0] quad_a_input;
    logic [3:0] quad_b_input;
    logic [3:0] quad_index_input;
    logic [7:0] dedicated_input;
  } sep_in_t;

  // field-side output pins, also used for their enables
  typedef struct packed {
    logic [3:0] pwm_up_pin;
    logic [3:0] pwm_down_pin;
    logic [9:0] dedicated_output;
  } sep_pins_t;
endpackage : sep_pkg
`default_nettype wire

// ### sep_servo_io.sv
// Overview of operation
// - watchdog tristates pins after 6.5 ms silence
// - host shutdown also holds pins tristated
// - direction high for negative, invert reverses
// - index recognised on rising edge
// - index filter rejects pulses under 175 ns
// - led is up0 xor down0
// - four counters decode every a/b edge
// - counters unambiguous to 8191 counts
// - 4095 signed duty steps including zero
// - pwm period is 2047 clock cycles
// - selectable pdm-like modulation mode
// - pwmdir select puts pwm/direction on pins
// - up/down mode: up idle when negative, down otherwise
// - shared outputs xored onto pwm pins
// - every output has an invert option
// - quadrature pins readable as inputs 8-19
// - 18 outputs and 20 inputs provided
// - dedicated outputs update together
// - each pwm channel updates independently
// - all twenty inputs captured at once
// - each channel position captured separately
// - host exchanges everything over the bus
`timescale 1ns/1ns
`default_nettype none
module sep_servo_io #(
  parameter int unsigned P_WD_CYC = sep_pkg::SEP_WD_CYC
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [3:0]         i_wb_sel,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [31:0]        i_wb_dat,
  output logic      [31:0]        o_wb_dat,
  output logic                    o_wb_ack,
  input  wire sep_pkg::sep_in_t   i_field,
  output var sep_pkg::sep_pins_t  o_pin,
  output var sep_pkg::sep_pins_t  o_pin_oe,
  output logic                    o_led
);
  import sep_pkg::*;

  typedef struct packed {
    logic [3:0]                      a_m;
    logic [3:0]                      a_s;
    logic [3:0]                      a_p;
    logic [3:0]                      b_m;
    logic [3:0]                      b_s;
    logic [3:0]                      b_p;
    logic [3:0]                      z_m;
    logic [3:0]                      z_s;
    logic [7:0]                      d_m;
    logic [7:0]                      d_s;
    logic [3:0][SEP_ZF_W-1:0]        z_cnt;
    logic [3:0]                      z_f;
    logic [3:0]                      z_seen;
    logic [3:0][SEP_QW-1:0]          qcnt;
    logic [10:0]                     pcnt;
    logic [3:0][11:0]                duty;
    logic [3:0][1:0]                 sh;
    logic [3:0][10:0]                acc;
    logic [3:0]                      pdir;
    logic [3:0]                      pdm;
    logic [9:0]                      dout;
    logic [17:0]                     inv;
    logic                            wd_en;
    logic                            shut;
    logic                            trip;
    logic [SEP_WD_W-1:0]             wd_cnt;
    logic                            ack;
    logic [31:0]                     dat;
    sep_pins_t                       pins;
    logic                            oe;
    logic                            led;
  } sep_st_t;

  sep_st_t r;
  sep_st_t next_r;

  // magnitude of a signed duty word, -2048 clamps to full scale
  function automatic logic [10:0] sep_mag(input logic [11:0] d);
    logic [11:0] t;
    t = d[11] ? (~d + 12'h001) : d;
    return t[11] ? 11'h7FF : t[10:0];
  endfunction : sep_mag

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] sep_merge(input logic [31:0] o,
                                            input logic [31:0] w,
                                            input logic [3:0]  s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return m;
  endfunction : sep_merge

  logic        bus_req;
  logic [1:0]  ch_sel;
  logic [31:0] ctrl_word;
  logic [31:0] wv;
  logic [11:0] acc_sum;
  logic [10:0] mag;
  logic        pulse;
  logic        neg;
  logic        up;
  logic        dn;

  // one next-state process for the whole block
  always_comb begin
    next_r    = r;
    bus_req   = i_wb_cyc & i_wb_stb & ~r.ack;
    ch_sel    = i_wb_adr[3:2];
    ctrl_word = 32'h0000_0000;
    wv        = 32'h0000_0000;
    acc_sum   = 12'h000;
    mag       = 11'h000;
    pulse     = 1'b0;
    neg       = 1'b0;
    up        = 1'b0;
    dn        = 1'b0;
    ctrl_word[SEP_CTRL_WDEN]       = r.wd_en;
    ctrl_word[SEP_CTRL_SHUT]       = r.shut;
    ctrl_word[SEP_CTRL_PDIR +: 4]  = r.pdir;
    ctrl_word[SEP_CTRL_PDM +: 4]   = r.pdm;

    // pin synchronisers: first stage feeds only the second
    next_r.a_m = i_field.quad_a_input;
    next_r.a_s = r.a_m;
    next_r.a_p = r.a_s;
    next_r.b_m = i_field.quad_b_input;
    next_r.b_s = r.b_m;
    next_r.b_p = r.b_s;
    next_r.z_m = i_field.quad_index_input;
    next_r.z_s = r.z_m;
    next_r.d_m = i_field.dedicated_input;
    next_r.d_s = r.d_m;

    // wishbone slave, one cycle to ack, unmapped reads give zero
    next_r.ack = bus_req;
    next_r.dat = 32'h0000_0000;
    if (bus_req) begin
      next_r.wd_cnt = '0; // any access counts as host traffic
      if (i_wb_adr[1:0] != 2'b00) begin
        next_r.dat = 32'h0000_0000;
      end else if (i_wb_adr[7:4] == SEP_PAGE_PWM) begin
        next_r.dat = {18'h00000, r.sh[ch_sel], r.duty[ch_sel]};
        if (i_wb_we) begin
          wv = sep_merge(next_r.dat, i_wb_dat, i_wb_sel);
          next_r.duty[ch_sel] = wv[11:0];
          next_r.sh[ch_sel]   = wv[SEP_PWM_SH +: 2];
        end
      end else if (i_wb_adr[7:4] == SEP_PAGE_Q) begin
        // position snapshot for this channel only
        next_r.dat = {17'h00000, r.z_seen[ch_sel], r.qcnt[ch_sel]};
        if (!i_wb_we) begin
          next_r.z_seen[ch_sel] = 1'b0;
        end
      end else begin
        case (i_wb_adr)
          SEP_OFS_CTRL: begin
            next_r.dat = ctrl_word;
            if (i_wb_we) begin
              wv = sep_merge(ctrl_word, i_wb_dat, i_wb_sel);
              next_r.wd_en = wv[SEP_CTRL_WDEN];
              next_r.shut  = wv[SEP_CTRL_SHUT];
              next_r.pdir  = wv[SEP_CTRL_PDIR +: 4];
              next_r.pdm   = wv[SEP_CTRL_PDM +: 4];
              next_r.trip  = 1'b0; // writing control re-arms the pins
            end
          end
          SEP_OFS_DOUT: begin
            next_r.dat = {22'h000000, r.dout};
            if (i_wb_we) begin
              wv = sep_merge(next_r.dat, i_wb_dat, i_wb_sel);
              next_r.dout = wv[9:0];
            end
          end
          SEP_OFS_INV: begin
            next_r.dat = {14'h0000, r.inv};
            if (i_wb_we) begin
              wv = sep_merge(next_r.dat, i_wb_dat, i_wb_sel);
              next_r.inv = wv[17:0];
            end
          end
          SEP_OFS_DIN: begin
            // all twenty inputs latched in one edge
            next_r.dat = {12'h000, r.b_s, r.a_s, r.z_s, r.d_s};
          end
          SEP_OFS_STAT: begin
            next_r.dat[SEP_ST_OE]   = r.oe;
            next_r.dat[SEP_ST_TRIP] = r.trip;
          end
          default: begin
            next_r.dat = 32'h0000_0000;
          end
        endcase
      end
    end

    // pwm carrier counter, 2047 states
    if (r.pcnt == SEP_PWM_PER - 11'h001) begin
      next_r.pcnt = 11'h000;
    end else begin
      next_r.pcnt = r.pcnt + 11'h001;
    end

    for (int c = 0; c < 4; c++) begin
      // 4x decode: exactly one of a or b moved since last sample
      if ((r.a_s[c] ^ r.a_p[c]) ^ (r.b_s[c] ^ r.b_p[c])) begin
        if (r.a_s[c] ^ r.b_p[c]) begin
          next_r.qcnt[c] = r.qcnt[c] + 14'h0001;
        end else begin
          next_r.qcnt[c] = r.qcnt[c] - 14'h0001;
        end
      end

      // index filter: the new level must persist before it is believed
      if (r.z_s[c] != r.z_f[c]) begin
        if (r.z_cnt[c] == SEP_ZF_W'(SEP_ZF_CYC - 1)) begin
          next_r.z_f[c]   = r.z_s[c];
          next_r.z_cnt[c] = '0;
        end else begin
          next_r.z_cnt[c] = r.z_cnt[c] + SEP_ZF_W'(1);
        end
      end else begin
        next_r.z_cnt[c] = '0;
      end
      // rising edge sets the flag after any read clear, so it is kept
      if (next_r.z_f[c] && !r.z_f[c]) begin
        next_r.z_seen[c] = 1'b1;
      end

      mag = sep_mag(r.duty[c]);
      neg = r.duty[c][11];
      if (r.pdm[c]) begin
        // pdm: first-order accumulator spreads pulses over the period
        acc_sum = {1'b0, r.acc[c]} + {1'b0, mag};
        if (acc_sum >= {1'b0, SEP_PWM_PER}) begin
          next_r.acc[c] = 11'(acc_sum - {1'b0, SEP_PWM_PER});
          pulse = 1'b1;
        end else begin
          next_r.acc[c] = acc_sum[10:0];
          pulse = 1'b0;
        end
      end else begin
        pulse = mag > r.pcnt;
      end
      if (r.pdir[c]) begin
        up = pulse;
        dn = neg;
      end else begin
        up = pulse & ~neg;
        dn = pulse & neg;
      end
      // shared output xored in, then the pin's invert option
      next_r.pins.pwm_up_pin[c] =
        up ^ r.sh[c][0] ^ r.inv[SEP_INV_SH + 2*c];
      next_r.pins.pwm_down_pin[c] =
        dn ^ r.sh[c][1] ^ r.inv[SEP_INV_SH + 2*c + 1];
    end
    next_r.pins.dedicated_output = r.dout ^ r.inv[9:0];
    next_r.led = next_r.pins.pwm_up_pin[0] ^ next_r.pins.pwm_down_pin[0];

    // watchdog; runs only in cycles without a bus access, so it never meets a same-cycle re-arm
    if (!bus_req) begin
      if (r.wd_en && r.wd_cnt == SEP_WD_W'(P_WD_CYC - 1)) begin
        next_r.trip = 1'b1;
      end else if (r.wd_cnt != SEP_WD_W'(P_WD_CYC - 1)) begin
        next_r.wd_cnt = r.wd_cnt + SEP_WD_W'(1);
      end
    end
    next_r.oe = ~next_r.trip & ~next_r.shut;
  end

  // state register; pins start tristated as on an unconfigured part
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r       <= '0;
      r.wd_en <= SEP_RST_WDEN;
      r.trip  <= SEP_RST_TRIP;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign o_wb_ack = r.ack;
  assign o_wb_dat = r.dat;
  assign o_pin    = r.pins;
  assign o_pin_oe = sep_pins_t'({18{r.oe}});
  assign o_led    = r.led;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  wd_trip_off_a: assert property (r.trip |-> o_pin_oe == '0)
    else $error("pins driven while watchdog tripped");

  wd_fires_a: assert property (
    (r.wd_en && !bus_req && r.wd_cnt == SEP_WD_W'(P_WD_CYC - 1))
      |=> r.trip && o_pin_oe == '0)
    else $error("watchdog expiry did not tristate pins");

  shut_off_a: assert property (r.shut |-> o_pin_oe == '0)
    else $error("pins driven after host shutdown");

  dir_level_a: assert property (
    r.pdir[0] |=> o_pin.pwm_down_pin[0] ==
      ($past(r.duty[0][11]) ^ $past(r.sh[0][1]) ^ $past(r.inv[11])))
    else $error("direction pin level wrong");

  index_edge_a: assert property ($rose(r.z_f[0]) |-> r.z_seen[0])
    else $error("index rising edge not flagged");

  index_filter_a: assert property (
    $changed(r.z_f[0]) |-> $past(r.z_s[0], 2) == r.z_f[0])
    else $error("index accepted a too short pulse");

  led_mirror_a: assert property (
    $changed(o_pin.pwm_up_pin[0] ^ o_pin.pwm_down_pin[0]) |-> $changed(o_led))
    else $error("led does not follow channel 0");

  quad_step_a: assert property (
    ((r.a_s[0] ^ r.a_p[0]) ^ (r.b_s[0] ^ r.b_p[0])) |=>
      (r.qcnt[0] - $past(r.qcnt[0]) == 14'h0001) ||
      ($past(r.qcnt[0]) - r.qcnt[0] == 14'h0001))
    else $error("quadrature edge not counted by one");

  pwm_wrap_a: assert property (
    r.pcnt == SEP_PWM_PER - 11'h001 |=> r.pcnt == 11'h000)
    else $error("pwm period not 2047 cycles");

  updown_idle_a: assert property (
    (!r.pdir[0] && r.duty[0][11] && r.sh[0] == 2'b00 && r.inv[11:10] == 2'b00)
      |=> !o_pin.pwm_up_pin[0])
    else $error("up pin active for negative command");

  bus_ack_a: assert property (bus_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single cycle");

  qcnt_hold_a: assert property (
    !((r.a_s[0] ^ r.a_p[0]) ^ (r.b_s[0] ^ r.b_p[0])) |=>
      r.qcnt[0] == $past(r.qcnt[0]))
    else $error("count moved without a single a/b edge");

  dout_mirror_a: assert property (
    o_pin.dedicated_output == $past(r.dout ^ r.inv[9:0]))
    else $error("dedicated outputs not updated together");

  pwm_zero_a: assert property (
    (r.duty[0] == 12'h000 && r.sh[0] == 2'b00 && r.inv[11:10] == 2'b00)
      |=> !o_pin.pwm_up_pin[0] && !o_pin.pwm_down_pin[0])
    else $error("zero duty drives a pin");

  pwm_full_a: assert property (
    (r.duty[0] == 12'h7FF && !r.pdir[0] && r.sh[0] == 2'b00 && r.inv[11:10] == 2'b00)
      |=> o_pin.pwm_up_pin[0])
    else $error("full duty not held high");

  down_idle_a: assert property (
    (!r.pdir[0] && !r.duty[0][11] && r.sh[0] == 2'b00 && r.inv[11:10] == 2'b00)
      |=> !o_pin.pwm_down_pin[0])
    else $error("down pin active for positive command");

  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data present without ack");
endmodule : sep_servo_io
`default_nettype wire

// ### sep_field_model.sv
`timescale 1ns/1ns
`default_nettype none
module sep_field_model (
  input  wire logic             i_clk,
  input  wire logic [19:0]      i_bg,
  output var sep_pkg::sep_in_t  o_field
);
  import sep_pkg::*;
  logic [1:0] ph;
  logic       z;

  initial begin
    ph = 2'h0;
    z  = 1'b0;
  end

  // channel 0 comes from the encoder model, every other pin from background bits
  always_comb begin
    o_field                     = sep_in_t'(i_bg);
    o_field.quad_a_input[0]     = ph[0] ^ ph[1];
    o_field.quad_b_input[0]     = ph[1];
    o_field.quad_index_input[0] = z;
  end

  // gray steps, one edge every two cycles so no two lines move in one sample
  task automatic step(input int n, input logic up);
    repeat (n) begin
      @(posedge i_clk);
      ph <= up ? ph + 2'h1 : ph - 2'h1;
      @(posedge i_clk);
    end
  endtask : step

  // index pulse high for len cycles
  task automatic pulse(input int len);
    @(posedge i_clk);
    z <= 1'b1;
    repeat (len) @(posedge i_clk);
    z <= 1'b0;
  endtask : pulse
endmodule : sep_field_model
`default_nettype wire

// ### sep_servo_io_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sep_servo_io_tb_top;
  import sep_pkg::*;
  logic        sys_clk, nrst, cyc, stb, we, ack, led;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q, c0, lf;
  logic [19:0] bg;
  logic [11:0] dt [6];
  sep_in_t     fld;
  sep_pins_t   pin, oe;
  int          error_cnt, n_compared, nu, nd, nl, nt, i;

  sep_servo_io #(.P_WD_CYC(50)) sep_servo_io_inst (.i_sys_clk(sys_clk), .i_nrst(nrst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_sel(sel), .i_wb_adr(adr),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_field(fld), .o_pin(pin),
    .o_pin_oe(oe), .o_led(led));
  sep_field_model sep_field_model_inst (.i_clk(sys_clk), .i_bg(bg), .o_field(fld));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h0);
  endfunction : lfsr

  // high cycles expected on one pin of an up/down pair; full negative clamps
  function automatic int exp_hi(input logic [11:0] d, input logic up);
    logic [11:0] n;
    int          m;
    n = 12'h000 - d; // twelve-bit negate, so the magnitude is not sign-extended
    m = d[11] ? ((d == 12'h800) ? 2047 : int'(n)) : int'(d);
    return (up ^ d[11]) ? m : 0;
  endfunction : exp_hi

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic give_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hF, a, d};
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (k == 20) begin
      chk(32'(ack), 32'h1);
      give_verdict();
    end
  endtask : wb

  // one full carrier period, whatever its phase
  task automatic period;
    logic pu;
    {nu, nd, nl, nt} = '0;
    pu = 1'b1;
    repeat (2047) begin
      @(posedge sys_clk);
      nu += int'(pin.pwm_up_pin[0]);
      nd += int'(pin.pwm_down_pin[0]);
      nl += int'(led !== (pin.pwm_up_pin[0] ^ pin.pwm_down_pin[0]));
      // rising edges tell dense pulses apart from one plain pwm pulse
      nt += int'(pin.pwm_up_pin[0] & ~pu);
      pu = pin.pwm_up_pin[0];
    end
  endtask : period

  // move channel 0 and compare the wrapped difference between two reads
  task automatic qrun(input int n, input logic up);
    sep_field_model_inst.step(n, up);
    repeat (6) @(posedge sys_clk);
    wb(1'b0, 8'h30, 32'h0);
    chk((q - c0) & 32'h3FFF, (up ? n : -n) & 32'h3FFF);
    c0 = q;
  endtask : qrun

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    {nrst, cyc, stb, we, sel, adr, wdat} = '0;
    bg = '0;
    lf = 32'h336785ED;
    error_cnt = 0;
    n_compared = 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    // floating out of reset, then armed, then left alone past the trip time
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h2);
    wb(1'b1, 8'h00, 32'h1);
    repeat (40) @(posedge sys_clk);
    chk(32'(oe), 32'h3FFFF);
    repeat (20) @(posedge sys_clk);
    chk(32'(oe), 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk(32'(oe), 32'h0);
    // run mode with the watchdog off so long measurements are safe
    wb(1'b1, 8'h00, 32'h0);
    for (i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      c0 = lf;
      wb(1'b1, 8'h08, {22'h0, c0[9:0]});
      lf = lfsr(lf);
      wb(1'b1, 8'h04, {22'h0, lf[9:0]});
      repeat (3) @(posedge sys_clk);
      chk(32'(pin.dedicated_output), 32'(c0[9:0] ^ lf[9:0]));
      wb(1'b0, 8'h04, 32'h0);
      chk(q, {22'h0, lf[9:0]});
      lf = lfsr(lf);
      bg <= lf[19:0];
      repeat (6) @(posedge sys_clk);
      wb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'({fld.quad_b_input, fld.quad_a_input, fld[11:0]}));
    end
    // direction pin, with and without its invert
    wb(1'b1, 8'h00, 32'h100);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, 8'h08, i[1] ? 32'h800 : 32'h0);
      wb(1'b1, 8'h20, i[0] ? 32'hFFB : 32'h005);
      repeat (4) @(posedge sys_clk);
      chk(32'(pin.pwm_down_pin[0]), 32'(i[0] ^ i[1]));
    end
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    lf = lfsr(lf);
    dt = '{12'h007, 12'hFF7, 12'h7FF, 12'h800, 12'h000, lf[11:0]};
    for (i = 0; i < 6; i++) begin
      wb(1'b1, 8'h20, {20'h0, dt[i]});
      repeat (4) @(posedge sys_clk);
      period();
      chk(32'(nu), 32'(exp_hi(dt[i], 1'b1)));
      chk(32'(nd), 32'(exp_hi(dt[i], 1'b0)));
      chk(32'(nl), 32'h0);
    end
    // dense-pulse option spreads the same energy
    wb(1'b1, 8'h00, 32'h1000);
    wb(1'b1, 8'h20, 32'h3FF);
    repeat (4) @(posedge sys_clk);
    period();
    chk(32'(nu >= 1022 && nu <= 1024), 32'h1);
    chk(32'(nt >= 512), 32'h1);
    // shared outputs on an idle channel
    wb(1'b1, 8'h00, 32'h0);
    for (i = 1; i < 4; i++) begin
      wb(1'b1, 8'h20, i << 12);
      repeat (4) @(posedge sys_clk);
      chk(32'({pin.pwm_up_pin[0], pin.pwm_down_pin[0]}), 32'({i[0], i[1]}));
    end
    wb(1'b0, 8'h30, 32'h0);
    c0 = q;
    lf = lfsr(lf);
    qrun(int'(lf[4:0]) + 3, 1'b1);
    qrun(60, 1'b0);
    qrun(8191, 1'b1);
    // boundary pulse lengths on the index filter
    wb(1'b0, 8'h30, 32'h0);
    sep_field_model_inst.pulse(1);
    repeat (8) @(posedge sys_clk);
    wb(1'b0, 8'h30, 32'h0);
    chk(32'(q[14]), 32'h0);
    sep_field_model_inst.pulse(2);
    repeat (8) @(posedge sys_clk);
    wb(1'b0, 8'h30, 32'h0);
    chk(32'(q[14]), 32'h1);
    give_verdict();
  end
endmodule : sep_servo_io_tb_top
`default_nettype wire
